// ### hdl/pad_threshold.sv
`timescale 1ns/1ns
module pad_threshold
    import sel_lock_pkg::*;
(
    input wire logic [SEL_W-1:0] pin_idx_i,
    input wire logic i2c_mode_i,
    input wire logic threshold_sel_i,
    output logic use_i2c_buf_o,
    output logic use_st_buf_o
);
    function automatic logic is_i2c_pin(input logic [SEL_W-1:0] p);
        is_i2c_pin = (p == I2C_PIN_A) || (p == I2C_PIN_B) ||
                     (p == I2C_PIN_C) || (p == I2C_PIN_D);
    endfunction

    always_comb begin
        use_i2c_buf_o = i2c_mode_i && is_i2c_pin(pin_idx_i); // R11
        // other pins fall back to the general buffer
        use_st_buf_o = !use_i2c_buf_o && threshold_sel_i; // R10
    end
endmodule

// ### hdl/pin_select_lock_control.sv
// Summary of operation
// (R1) while locked, every input and output selection write is ignored
// (R2) lock bit changes only after writes of 55 then AA
// (R3) any other write between steps aborts the unlock sequence
// (R4) with one-shot fuse, one clear and one set per reset; here the lock resets to 0 and no clear follows a set, so only one set
// (R5) with one-shot fuse, lock set after clear stays until reset
// (R6) sleep leaves all selections untouched
// (R7) power-on reset restores defaults and removes the permanent lock
// (R8) other resets keep the current selections
// (R9) software maps bidirectional input and output to one pin
// (R10) i2c on other pins uses the general threshold buffer
// (R11) i2c on designated pins overrides the threshold select
// (R12) software should map i2c only to designated pins
`timescale 1ns/1ns
module pin_select_lock_control
    import sel_lock_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic por_i,
    input wire logic sleep_i,
    input wire logic one_shot_lock_fuse_i,
    input wire logic lock_wr_i,
    input wire logic [7:0] lock_wdata_i,
    input wire logic sel_wr_i,
    input wire logic sel_is_out_i,
    input wire logic [2:0] sel_idx_i,
    input wire logic [SEL_W-1:0] sel_wdata_i,
    input wire logic other_wr_i,
    input wire logic i2c_mode_i,
    input wire logic [2:0] i2c_periph_i,
    input wire logic input_threshold_select_i,
    output logic selection_lock_bit_o,
    output logic [NUM_PERIPH*SEL_W-1:0] in_sel_o,
    output logic [NUM_PERIPH*SEL_W-1:0] out_sel_o,
    output logic i2c_buf_en_o,
    output logic st_buf_en_o
);
    typedef struct packed {
        seq_state_t seq;
        logic locked;
        logic cleared_once;
        logic set_once;
        logic [NUM_PERIPH-1:0][SEL_W-1:0] in_sel;
        logic [NUM_PERIPH-1:0][SEL_W-1:0] out_sel;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic key1;
    logic key2;
    logic new_lock;
    logic may_clear;
    logic may_set;

    always_comb begin
        s_d = s_q;
        key1 = lock_wr_i && (lock_wdata_i == UNLOCK_KEY_FIRST);
        key2 = lock_wr_i && (lock_wdata_i == UNLOCK_KEY_SECOND);
        new_lock = lock_wdata_i[LOCK_BIT_POS];
        // once set under the fuse, the lock stays until the next reset
        may_clear = !one_shot_lock_fuse_i ||
                    (!s_q.cleared_once && !s_q.set_once); // R4 R5
        may_set = !one_shot_lock_fuse_i || !s_q.set_once; // R5
        case (s_q.seq)
            SEQ_IDLE: begin
                if (key1) begin
                    s_d.seq = SEQ_GOT_FIRST;
                end
            end
            SEQ_GOT_FIRST: begin
                if (key2) begin
                    s_d.seq = SEQ_ARMED; // R2
                end else if (lock_wr_i || sel_wr_i || other_wr_i) begin
                    s_d.seq = key1 ? SEQ_GOT_FIRST : SEQ_IDLE; // R3
                end
            end
            SEQ_ARMED: begin
                if (lock_wr_i) begin
                    s_d.seq = SEQ_IDLE;
                    if (!new_lock && s_q.locked && may_clear) begin
                        s_d.locked = 1'b0; // R2
                        s_d.cleared_once = 1'b1; // R4
                    end else if (new_lock && !s_q.locked && may_set) begin
                        s_d.locked = 1'b1; // R2
                        s_d.set_once = 1'b1; // R5
                    end
                end else if (sel_wr_i || other_wr_i) begin
                    s_d.seq = SEQ_IDLE; // R3
                end
            end
            default: begin
                s_d.seq = SEQ_IDLE;
            end
        endcase
        // selection updates; sleep is deliberately not a term here
        if (sel_wr_i && !s_q.locked) begin // R1 R6
            if (sel_is_out_i) begin
                s_d.out_sel[sel_idx_i] = sel_wdata_i;
            end else begin
                s_d.in_sel[sel_idx_i] = sel_wdata_i;
            end
        end
        // por restores defaults, other resets keep the selections
        if (por_i) begin
            s_d.seq = SEQ_IDLE;
            s_d.locked = LOCK_RESET_VALUE;
            s_d.cleared_once = 1'b0; // R7
            s_d.set_once = 1'b0; // R7
            s_d.in_sel = {NUM_PERIPH{SEL_DEFAULT}}; // R7
            s_d.out_sel = {NUM_PERIPH{SEL_DEFAULT}}; // R7
        end else if (rst_i) begin
            s_d.seq = SEQ_IDLE;
            s_d.locked = LOCK_RESET_VALUE;
            s_d.cleared_once = 1'b0; // R4
            s_d.set_once = 1'b0; // R4
            s_d.in_sel = s_q.in_sel; // R8
            s_d.out_sel = s_q.out_sel; // R8
        end
    end

    always_ff @(posedge mclk_i) begin
        s_q <= s_d;
    end

    assign selection_lock_bit_o = s_q.locked;
    assign in_sel_o = s_q.in_sel;
    assign out_sel_o = s_q.out_sel;

    // i2c buffer choice follows the pin mapped to the i2c input
    pad_threshold u_pad_threshold (
        .pin_idx_i(s_q.in_sel[i2c_periph_i]),
        .i2c_mode_i(i2c_mode_i),
        .threshold_sel_i(input_threshold_select_i),
        .use_i2c_buf_o(i2c_buf_en_o),
        .use_st_buf_o(st_buf_en_o)
    );

    // checks
    a_locked_holds_sel: assert property (@(posedge mclk_i) // R1
        disable iff (rst_i || por_i)
        s_q.locked |=> $stable(s_q.in_sel) && $stable(s_q.out_sel))
        else $error("selection changed while locked");
    a_in_write_lands: assert property (@(posedge mclk_i) // R1
        disable iff (rst_i || por_i)
        (sel_wr_i && !sel_is_out_i && !s_q.locked)
        |=> s_q.in_sel[$past(sel_idx_i)] == $past(sel_wdata_i))
        else $error("input selection write lost");
    a_out_write_lands: assert property (@(posedge mclk_i) // R1
        disable iff (rst_i || por_i)
        (sel_wr_i && sel_is_out_i && !s_q.locked)
        |=> s_q.out_sel[$past(sel_idx_i)] == $past(sel_wdata_i))
        else $error("output selection write lost");
    a_lock_needs_keys: assert property (@(posedge mclk_i) // R2
        disable iff (rst_i || por_i)
        ($changed(s_q.locked) && !$past(rst_i) && !$past(por_i))
        |-> $past(s_q.seq) == SEQ_ARMED)
        else $error("lock changed without unlock keys");
    a_second_key_arms: assert property (@(posedge mclk_i) // R2
        disable iff (rst_i || por_i)
        (s_q.seq == SEQ_GOT_FIRST && lock_wr_i
            && lock_wdata_i == UNLOCK_KEY_SECOND)
        |=> s_q.seq == SEQ_ARMED)
        else $error("second key did not arm the sequence");
    a_armed_sets_lock: assert property (@(posedge mclk_i) // R2
        disable iff (rst_i || por_i)
        (s_q.seq == SEQ_ARMED && lock_wr_i && lock_wdata_i[LOCK_BIT_POS]
            && !s_q.locked && !one_shot_lock_fuse_i)
        |=> s_q.locked)
        else $error("armed lock write did not set the lock");
    a_armed_clears_lock: assert property (@(posedge mclk_i) // R2
        disable iff (rst_i || por_i)
        (s_q.seq == SEQ_ARMED && lock_wr_i && !lock_wdata_i[LOCK_BIT_POS]
            && s_q.locked && !one_shot_lock_fuse_i)
        |=> !s_q.locked)
        else $error("armed lock write did not clear the lock");
    a_abort_seq: assert property (@(posedge mclk_i) // R3
        disable iff (rst_i || por_i)
        (s_q.seq == SEQ_ARMED && !lock_wr_i && (sel_wr_i || other_wr_i))
        |=> s_q.seq == SEQ_IDLE && $stable(s_q.locked))
        else $error("sequence not discarded");
    a_idle_ignores: assert property (@(posedge mclk_i) // R3
        disable iff (rst_i || por_i)
        (s_q.seq == SEQ_IDLE && lock_wr_i
            && lock_wdata_i != UNLOCK_KEY_FIRST)
        |=> s_q.seq == SEQ_IDLE && $stable(s_q.locked))
        else $error("stray lock write was not ignored");
    a_one_clear: assert property (@(posedge mclk_i) // R4
        disable iff (rst_i || por_i)
        (one_shot_lock_fuse_i && s_q.cleared_once) |=> !$fell(s_q.locked))
        else $error("second clear with fuse");
    a_fuse_one_set: assert property (@(posedge mclk_i) // R4
        disable iff (rst_i || por_i)
        (one_shot_lock_fuse_i && s_q.set_once) |=> !$rose(s_q.locked))
        else $error("second set with fuse");
    a_perm_lock: assert property (@(posedge mclk_i) // R5
        disable iff (rst_i || por_i)
        (one_shot_lock_fuse_i && s_q.set_once && s_q.locked)
        |=> s_q.locked)
        else $error("permanent lock released");
    a_sleep_stable: assert property (@(posedge mclk_i) // R6
        disable iff (rst_i || por_i)
        ($changed(sleep_i) && !sel_wr_i) |=> $stable(s_q.in_sel))
        else $error("sleep altered selection");
    a_por_default: assert property (@(posedge mclk_i) // R7
        por_i |=> s_q.in_sel == {NUM_PERIPH{SEL_DEFAULT}}
            && s_q.out_sel == {NUM_PERIPH{SEL_DEFAULT}}
            && !s_q.set_once && !s_q.locked)
        else $error("por did not restore defaults");
    a_rst_keeps: assert property (@(posedge mclk_i) // R8
        disable iff (por_i)
        rst_i |=> $stable(s_q.out_sel) && $stable(s_q.in_sel))
        else $error("reset changed selections");

    // i2c pad choice
    a_general_buffer: assert property (@(posedge mclk_i) // R10
        !i2c_buf_en_o |-> st_buf_en_o == input_threshold_select_i)
        else $error("general buffer ignores threshold select");
    a_i2c_override: assert property (@(posedge mclk_i) // R11
        (i2c_buf_en_o) |-> !st_buf_en_o && i2c_mode_i)
        else $error("i2c buffer conflict");

    // cover points
    c_unlock: cover property (@(posedge mclk_i) $fell(s_q.locked));
    c_lock: cover property (@(posedge mclk_i) $rose(s_q.locked));
    c_abort: cover property (@(posedge mclk_i)
        s_q.seq == SEQ_GOT_FIRST && other_wr_i);
    c_perm_refused: cover property (@(posedge mclk_i)
        one_shot_lock_fuse_i && s_q.set_once && s_q.seq == SEQ_ARMED
        && lock_wr_i);
    c_i2c_pad: cover property (@(posedge mclk_i) i2c_buf_en_o);
endmodule

// ### hdl/sel_lock_pkg.sv
package sel_lock_pkg;
    localparam int NUM_PERIPH = 8;
    localparam int NUM_PINS = 16;
    localparam int SEL_W = 4;
    localparam logic [7:0] UNLOCK_KEY_FIRST = 8'h55;
    localparam logic [7:0] UNLOCK_KEY_SECOND = 8'hAA;
    localparam int LOCK_BIT_POS = 0;
    localparam logic LOCK_RESET_VALUE = 1'b0;
    localparam logic [SEL_W-1:0] SEL_DEFAULT = 4'h0;
    // designated i2c-capable pin indices
    localparam logic [SEL_W-1:0] I2C_PIN_A = 4'h1;
    localparam logic [SEL_W-1:0] I2C_PIN_B = 4'h2;
    localparam logic [SEL_W-1:0] I2C_PIN_C = 4'hB;
    localparam logic [SEL_W-1:0] I2C_PIN_D = 4'hC;
    // unlock sequence states, gray from idle to armed; the return from armed to idle flips both bits
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_GOT_FIRST = 2'b01,
        SEQ_ARMED = 2'b11
    } seq_state_t;
endpackage

// ### verif/testbench.sv
`timescale 1ns/1ns
module testbench
    import sel_lock_pkg::*;
;
    logic mclk_i = 0, rst_i = 1, por_i = 1, sleep_i = 0, fuse_i = 0;
    logic lock_wr_i = 0, sel_wr_i = 0, sel_is_out_i = 0, other_wr_i = 0;
    logic i2c_mode_i = 0, thr_i = 0;
    logic [7:0] lock_wdata_i = 8'h00;
    logic [2:0] sel_idx_i = 3'h0, i2c_periph_i = 3'h0;
    logic [SEL_W-1:0] sel_wdata_i = 4'h0;
    logic lock_o, i2c_o, st_o;
    logic [NUM_PERIPH*SEL_W-1:0] in_o, out_o;
    logic [SEL_W-1:0] pins [5];
    int n_errors = 0, samples_checked = 0, cycles = 0;
    pin_select_lock_control i_dut (.mclk_i(mclk_i), .rst_i(rst_i),
        .por_i(por_i), .sleep_i(sleep_i), .one_shot_lock_fuse_i(fuse_i),
        .lock_wr_i(lock_wr_i), .lock_wdata_i(lock_wdata_i),
        .sel_wr_i(sel_wr_i), .sel_is_out_i(sel_is_out_i),
        .sel_idx_i(sel_idx_i), .sel_wdata_i(sel_wdata_i),
        .other_wr_i(other_wr_i), .i2c_mode_i(i2c_mode_i),
        .i2c_periph_i(i2c_periph_i), .input_threshold_select_i(thr_i),
        .selection_lock_bit_o(lock_o), .in_sel_o(in_o), .out_sel_o(out_o),
        .i2c_buf_en_o(i2c_o), .st_buf_en_o(st_o));
    always #50 mclk_i = ~mclk_i;
    task check(input string name, input logic [31:0] seen,
               input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task final_report;
        $display("checked %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task lk(input logic [7:0] d);
        @(posedge mclk_i);
        #1 lock_wr_i = 1;
        lock_wdata_i = d;
        @(posedge mclk_i);
        #1 lock_wr_i = 0;
    endtask
    task seq(input logic [7:0] d);
        lk(UNLOCK_KEY_FIRST);
        lk(UNLOCK_KEY_SECOND);
        lk(d);
    endtask
    task sw(input logic o, input logic [2:0] k, input logic [SEL_W-1:0] p);
        @(posedge mclk_i);
        #1 sel_wr_i = 1;
        sel_is_out_i = o;
        sel_idx_i = k;
        sel_wdata_i = p;
        @(posedge mclk_i);
        #1 sel_wr_i = 0;
    endtask
    task rst_pulse(input logic p);
        @(posedge mclk_i);
        #1 rst_i = ~p;
        por_i = p;
        @(posedge mclk_i);
        #1 rst_i = 0;
        por_i = 0;
    endtask
    task wr_other;
        @(posedge mclk_i);
        #1 other_wr_i = 1;
        @(posedge mclk_i);
        #1 other_wr_i = 0;
    endtask
    task settle;
        @(posedge mclk_i);
        #1;
    endtask
    always @(posedge mclk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_errors++;
            final_report();
        end
    end
    initial begin
        repeat (8) @(posedge mclk_i);
        #1 rst_i = 0;
        por_i = 0;
        check("lock", lock_o, 0);
        check("in", in_o, 0);
        sw(0, 3, 4'h5);
        sw(1, 7, 4'hA);
        seq(8'h01);
        check("lock", lock_o, 1);
        sw(0, 3, 4'h9);
        sw(1, 0, 4'h3);
        check("in", in_o, 32'h00005000);
        check("out", out_o, 32'hA0000000);
        $display("test lock done");
        lk(8'h55);
        wr_other();
        lk(8'hAA);
        lk(8'h00);
        check("lock", lock_o, 1);
        lk(8'h55);
        lk(8'hAA);
        sw(0, 1, 4'h1);
        lk(8'h00);
        check("lock", lock_o, 1);
        lk(8'hAA);
        lk(8'h55);
        lk(8'h00);
        check("lock", lock_o, 1);
        seq(8'h00);
        check("lock", lock_o, 0);
        $display("test sequence done");
        sleep_i = 1;
        repeat (4) @(posedge mclk_i);
        #1 sleep_i = 0;
        check("in", in_o, 32'h00005000);
        check("out", out_o, 32'hA0000000);
        rst_pulse(0);
        check("in", in_o, 32'h00005000);
        check("out", out_o, 32'hA0000000);
        rst_pulse(1);
        check("out", out_o, 0);
        $display("test reset done");
        fuse_i = 1;
        seq(8'h00);
        seq(8'h01);
        check("lock", lock_o, 1);
        seq(8'h00);
        check("lock", lock_o, 1);
        sw(0, 1, 4'h4);
        check("in", in_o, 0);
        rst_pulse(1);
        seq(8'h00);
        seq(8'h01);
        check("lock", lock_o, 1);
        rst_pulse(1);
        fuse_i = 0;
        seq(8'h01);
        seq(8'h00);
        seq(8'h01);
        fuse_i = 1;
        seq(8'h00);
        check("lock", lock_o, 1);
        rst_pulse(1);
        fuse_i = 0;
        $display("test fuse done");
        pins = '{I2C_PIN_A, I2C_PIN_B, I2C_PIN_C, I2C_PIN_D, 4'h5};
        i2c_mode_i = 1;
        i2c_periph_i = 3'h2;
        thr_i = 1;
        for (int i = 0; i < 5; i++) begin
            sw(0, 2, pins[i]);
            sw(1, 2, pins[i]);
            check("i2c", i2c_o, i < 4);
            check("st", st_o, i >= 4);
        end
        check("out", out_o, 32'h00000500);
        check("st", st_o, 1);
        thr_i = 0;
        settle();
        check("st", st_o, 0);
        $display("test buffer done");
        final_report();
    end
endmodule
